// ### hw/rtci_pkg.sv
// shared constants and types of the rtc two-wire serial port
package rtci_pkg;
	// slave address with direction bit
	localparam logic [7:0] SLA_WR = 8'h64;
	localparam logic [7:0] SLA_RD = 8'h65;
	// register pointer
	localparam logic [3:0] PTR_RESET = 4'hf;
	localparam logic [3:0] REG_RSVD = 4'hd;
	// bit counter positions within a byte
	localparam logic [3:0] CNT_BYTE = 4'h8;
	localparam logic [3:0] CNT_ACK = 4'h9;
	// host byte roles within a transaction
	localparam logic [1:0] IDX_SLA = 2'h0;
	localparam logic [1:0] IDX_REGA = 2'h1;
	localparam logic [1:0] IDX_DATA = 2'h2;
	// host commands
	localparam logic [1:0] OP_START = 2'h0;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [1:0] OP_STOP = 2'h3;
	// timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int TOUT_MS = 500;
	localparam int TOUT_CYC = TOUT_MS * 1000000 / CLK_PERIOD_NS;
	localparam int GAP_NS = 62000;
	localparam int GAP_CYC = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SCL_HALF_NS = 5000;
	localparam int SCL_HALF_CYC = SCL_HALF_NS / CLK_PERIOD_NS;
	localparam int TMR_W = 27;
	localparam int TM_W = 16;
	typedef enum logic [2:0] {
		D_IDLE = 3'h0,
		D_SLA = 3'h1,
		D_REGA = 3'h2,
		D_WR = 3'h3,
		D_RD = 3'h4,
		D_WAITP = 3'h5
	} rtci_dst_e;
	typedef enum logic [2:0] {
		H_IDLE = 3'h0,
		H_START = 3'h1,
		H_BYTE = 3'h2,
		H_STOP = 3'h3,
		H_GAP = 3'h4
	} rtci_hst_e;
endpackage

// ### hw/rtci_if.sv
// open-drain two-wire bus joining host and rtc slave
`timescale 1ns/100ps
interface rtci_if;
	logic host_scl_o;
	logic host_scl_oe;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic scl;
	logic sda;
	// wired-and with pull-up: low when any enabled driver is low
	assign scl = !(host_scl_oe && !host_scl_o);
	assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));
	modport dev (input scl, sda, output dev_sda_o, dev_sda_oe);
	modport host (input scl, sda, output host_scl_o, host_scl_oe,
		host_sda_o, host_sda_oe);
endinterface

// ### hw/rtci_sync.sv
// two-flop synchroniser for bus pins
`timescale 1ns/100ps
module rtci_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '1
) (
	// clock, reset and enable
	input wire logic CLK,
	input wire logic RST,
	input wire logic CE,
	// asynchronous in, synchronous out
	input wire logic [W-1:0] D,
	output logic [W-1:0] Q
);
	logic [W-1:0] meta_q;
	always_ff @(posedge CLK) begin
		if (RST) begin
			meta_q <= RST_VAL;
			Q <= RST_VAL;
		end else if (CE) begin
			meta_q <= D;
			Q <= meta_q;
		end
	end
endmodule

// ### hw/rtci_dev.sv
// rtc end of the two-wire serial port
`timescale 1ns/100ps
module rtci_dev
	import rtci_pkg::*;
	#(parameter int TOUT_CYCLES = TOUT_CYC) (
	// clock, reset and enable
	input wire logic CLK,
	input wire logic RST,
	input wire logic CE,
	// two-wire bus
	rtci_if.dev BUS,
	// register access toward the clock core
	output logic [3:0] REG_ADDR,
	output logic [7:0] REG_WDATA,
	output logic REG_WE,
	input wire logic [7:0] REG_RDATA,
	output logic REG_RE,
	// status toward the clock core
	output logic CARRY_HOLD,
	output logic TIMEOUT
);
	logic [1:0] pin_s;
	logic scl_s;
	logic sda_s;
	logic scl_p_q;
	logic sda_p_q;
	rtci_dst_e st_q;
	rtci_dst_e st_d;
	logic [3:0] cnt_q;
	logic [3:0] cnt_d;
	logic [3:0] ptr_q;
	logic [3:0] ptr_d;
	logic [7:0] sh_q;
	logic [7:0] sh_d;
	logic [7:0] wdat_q;
	logic [7:0] wdat_d;
	logic oe_q;
	logic oe_d;
	logic busy_q;
	logic busy_d;
	logic we_q;
	logic we_d;
	logic tout_q;
	logic tout_d;
	logic [TMR_W-1:0] tm_q;
	logic [TMR_W-1:0] tm_d;

	// pins cross into the clock domain before any decode
	rtci_sync #(
		.W(2),
		.RST_VAL(2'h3)
	) u_sync (
		.CLK(CLK),
		.RST(RST),
		.CE(CE),
		.D({BUS.scl, BUS.sda}),
		.Q(pin_s)
	);

	assign scl_s = pin_s[1];
	assign sda_s = pin_s[0];

	// edge and condition decode on synchronised levels
	logic start_ev;
	logic stop_ev;
	logic scl_rise;
	logic scl_fall;
	logic byte_end;
	logic ack_end;
	logic rx_st;
	logic sla_hit;
	logic tout_hit;
	logic rd_load;
	logic ptr_inc;
	assign start_ev = scl_s && scl_p_q && sda_p_q && !sda_s;
	assign stop_ev = scl_s && scl_p_q && !sda_p_q && sda_s;
	assign scl_rise = scl_s && !scl_p_q;
	assign scl_fall = !scl_s && scl_p_q;
	assign byte_end = scl_fall && (cnt_q == CNT_BYTE);
	assign ack_end = scl_fall && (cnt_q == CNT_ACK);
	assign rx_st = (st_q == D_SLA) || (st_q == D_REGA) || (st_q == D_WR);
	assign sla_hit = (sh_q == SLA_WR) || (sh_q == SLA_RD);
	assign tout_hit = busy_q && (tm_q == TMR_W'(TOUT_CYCLES - 1));
	assign rd_load = !tout_hit && ack_end
		&& (((st_q == D_SLA) && sh_q[0]) || (st_q == D_RD));
	// wraps Fh to 0h by plain 4-bit overflow
	assign ptr_inc = rd_load || (!tout_hit && ack_end && (st_q == D_WR));

	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		ptr_d = ptr_q;
		sh_d = sh_q;
		wdat_d = wdat_q;
		oe_d = oe_q;
		busy_d = busy_q;
		we_d = 1'b0;
		tout_d = 1'b0;
		tm_d = busy_q ? tm_q + 1'b1 : '0;
		if (start_ev) begin
			st_d = D_SLA;
			cnt_d = '0;
			oe_d = 1'b0;
			busy_d = 1'b1;
			// repeated start keeps pointer and running time
			if (!busy_q) begin
				ptr_d = PTR_RESET;
				tm_d = '0;
			end
		end else if (stop_ev) begin
			st_d = D_IDLE;
			oe_d = 1'b0;
			busy_d = 1'b0;
		end else if (tout_hit) begin
			// released line makes any read return all ones
			st_d = D_IDLE;
			oe_d = 1'b0;
			busy_d = 1'b0;
			tout_d = 1'b1;
		end else begin
			if (scl_rise && (cnt_q != CNT_ACK)) begin
				cnt_d = cnt_q + 4'h1;
			end
			if (ack_end) begin
				cnt_d = '0;
			end
			if (ptr_inc) begin
				ptr_d = ptr_q + 4'h1;
			end
			if (rx_st) begin
				if (scl_rise && (cnt_q < CNT_BYTE)) begin
					sh_d = {sh_q[6:0], sda_s};
				end
				if (byte_end) begin
					oe_d = 1'b1;
				end
				if (ack_end) begin
					oe_d = 1'b0;
				end
			end
			case (st_q)
				D_SLA: begin
					if (byte_end && !sla_hit) begin
						st_d = D_WAITP;
						oe_d = 1'b0;
					end
					if (ack_end) begin
						st_d = sh_q[0] ? D_RD : D_REGA;
					end
					if (rd_load) begin
						sh_d = REG_RDATA;
						oe_d = !REG_RDATA[7];
					end
				end
				D_REGA: begin
					// low nibble carries the transfer mode, unused here
					if (byte_end) begin
						ptr_d = sh_q[7:4];
					end
					if (ack_end) begin
						st_d = D_WR;
					end
				end
				D_WR: begin
					if (byte_end) begin
						we_d = 1'b1;
						wdat_d = sh_q;
					end
				end
				D_RD: begin
					if (scl_rise && (cnt_q == CNT_BYTE) && sda_s) begin
						st_d = D_WAITP;
						oe_d = 1'b0;
					end
					if (scl_fall && (cnt_q != 4'h0) && (cnt_q < CNT_BYTE)) begin
						sh_d = {sh_q[6:0], 1'b0};
						oe_d = !sh_q[6];
					end
					if (byte_end) begin
						oe_d = 1'b0;
					end
					if (rd_load) begin
						sh_d = REG_RDATA;
						oe_d = !REG_RDATA[7];
					end
				end
				default: begin
					oe_d = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else if (CE) begin
			scl_p_q <= scl_s;
			sda_p_q <= sda_s;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			st_q <= D_IDLE;
			cnt_q <= '0;
			ptr_q <= PTR_RESET;
			sh_q <= '0;
			wdat_q <= '0;
			oe_q <= 1'b0;
		end else if (CE) begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			ptr_q <= ptr_d;
			sh_q <= sh_d;
			wdat_q <= wdat_d;
			oe_q <= oe_d;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			busy_q <= 1'b0;
			we_q <= 1'b0;
			tout_q <= 1'b0;
			tm_q <= '0;
		end else if (CE) begin
			busy_q <= busy_d;
			we_q <= we_d;
			tout_q <= tout_d;
			tm_q <= tm_d;
		end
	end

	assign BUS.dev_sda_o = 1'b0;
	assign BUS.dev_sda_oe = oe_q;
	assign REG_ADDR = ptr_q;
	assign REG_WDATA = wdat_q;
	assign REG_WE = we_q;
	assign REG_RE = CE && rd_load;
	// core holds carries while high, applies them once it drops
	assign CARRY_HOLD = busy_q;
	assign TIMEOUT = tout_q;
endmodule

// ### hw/rtci_host.sv
// master end of the rtc two-wire serial port
`timescale 1ns/100ps
module rtci_host
	import rtci_pkg::*;
	#(
	parameter int HALF_CYCLES = SCL_HALF_CYC,
	parameter int GAP_CYCLES = GAP_CYC,
	parameter int XACT_CYCLES = TOUT_CYC
) (
	// clock, reset and enable
	input wire logic CLK,
	input wire logic RST,
	input wire logic CE,
	// two-wire bus
	rtci_if.host BUS,
	// command port
	input wire logic CMD_VALID,
	output logic CMD_READY,
	input wire logic [1:0] CMD_OP,
	input wire logic [7:0] CMD_WDATA,
	input wire logic CMD_ACK,
	// response port
	output logic RSP_VALID,
	output logic [7:0] RSP_RDATA,
	output logic RSP_NACK,
	output logic RSP_ERR,
	output logic BUSY
);
	logic sda_s;
	rtci_hst_e st_q;
	rtci_hst_e st_d;
	logic [1:0] ph_q;
	logic [1:0] ph_d;
	logic [3:0] bit_q;
	logic [3:0] bit_d;
	logic [TM_W-1:0] tm_q;
	logic [TM_W-1:0] tm_d;
	logic [TMR_W-1:0] xt_q;
	logic [TMR_W-1:0] xt_d;
	logic [7:0] sh_q;
	logic [7:0] sh_d;
	logic [7:0] rdat_q;
	logic [7:0] rdat_d;
	logic [3:0] ptr_q;
	logic [3:0] ptr_d;
	logic [1:0] idx_q;
	logic [1:0] idx_d;
	logic scl_oe_q;
	logic scl_oe_d;
	logic sda_oe_q;
	logic sda_oe_d;
	logic rd_q;
	logic rd_d;
	logic ack_q;
	logic ack_d;
	logic busy_q;
	logic busy_d;
	logic rv_q;
	logic rv_d;
	logic nack_q;
	logic nack_d;
	logic err_q;
	logic err_d;

	rtci_sync #(
		.W(1),
		.RST_VAL(1'b1)
	) u_sync (
		.CLK(CLK),
		.RST(RST),
		.CE(CE),
		.D(BUS.sda),
		.Q(sda_s)
	);

	logic accept;
	logic tick;
	logic xact_over;
	logic op_byte;
	logic is_data;
	logic refuse;
	logic is_rd;
	assign CMD_READY = (st_q == H_IDLE);
	assign accept = CMD_VALID && CMD_READY;
	assign tick = (tm_q == TM_W'(HALF_CYCLES - 1));
	assign xact_over = (xt_q >= TMR_W'(XACT_CYCLES - 1));
	assign op_byte = (CMD_OP == OP_WRITE) || (CMD_OP == OP_READ);
	assign is_data = (idx_q == IDX_DATA);
	assign is_rd = (CMD_OP == OP_READ);
	// refused commands answer with an error and leave the bus alone
	assign refuse = op_byte ? (!busy_q || xact_over
		|| (is_data && (ptr_q == REG_RSVD))
		|| (is_rd && !is_data)) : ((CMD_OP == OP_STOP) && !busy_q);

	always_comb begin
		st_d = st_q;
		ph_d = ph_q;
		bit_d = bit_q;
		sh_d = sh_q;
		rdat_d = rdat_q;
		ptr_d = ptr_q;
		idx_d = idx_q;
		scl_oe_d = scl_oe_q;
		sda_oe_d = sda_oe_q;
		rd_d = rd_q;
		ack_d = ack_q;
		busy_d = busy_q;
		nack_d = nack_q;
		err_d = err_q;
		rv_d = 1'b0;
		tm_d = (st_q == H_IDLE) ? '0 : tm_q + 1'b1;
		xt_d = (busy_q && !xact_over) ? xt_q + 1'b1 : xt_q;
		case (st_q)
			H_IDLE: begin
				if (accept && refuse) begin
					rv_d = 1'b1;
					err_d = 1'b1;
					nack_d = 1'b0;
				end else if (accept) begin
					err_d = 1'b0;
					nack_d = 1'b0;
					ph_d = 2'h0;
					case (CMD_OP)
						OP_START: begin
							st_d = H_START;
							scl_oe_d = busy_q;
							sda_oe_d = 1'b0;
							idx_d = IDX_SLA;
							if (!busy_q) begin
								ptr_d = PTR_RESET;
								xt_d = '0;
							end
						end
						OP_STOP: begin
							st_d = H_STOP;
							scl_oe_d = 1'b1;
							sda_oe_d = 1'b1;
						end
						default: begin
							st_d = H_BYTE;
							bit_d = 4'h0;
							rd_d = is_rd;
							ack_d = CMD_ACK;
							sh_d = is_rd ? 8'hff : CMD_WDATA;
							sda_oe_d = !is_rd && !CMD_WDATA[7];
							scl_oe_d = 1'b1;
						end
					endcase
				end
			end
			H_START: begin
				if (tick) begin
					tm_d = '0;
					ph_d = ph_q + 2'h1;
					case (ph_q)
						2'h0: scl_oe_d = 1'b0;
						2'h1: sda_oe_d = 1'b1;
						2'h2: scl_oe_d = 1'b1;
						default: begin
							st_d = H_IDLE;
							busy_d = 1'b1;
							rv_d = 1'b1;
						end
					endcase
				end
			end
			H_STOP: begin
				if (tick) begin
					tm_d = '0;
					ph_d = ph_q + 2'h1;
					case (ph_q)
						2'h0: scl_oe_d = 1'b0;
						2'h1: sda_oe_d = 1'b0;
						default: begin
							st_d = H_GAP;
							busy_d = 1'b0;
							rv_d = 1'b1;
						end
					endcase
				end
			end
			H_GAP: begin
				if (tm_q == TM_W'(GAP_CYCLES - 1)) begin
					st_d = H_IDLE;
				end
			end
			H_BYTE: begin
				if (tick && !ph_q[0]) begin
					tm_d = '0;
					ph_d = 2'h1;
					scl_oe_d = 1'b0;
				end else if (tick) begin
					tm_d = '0;
					ph_d = 2'h0;
					scl_oe_d = 1'b1;
					if (bit_q == CNT_BYTE) begin
						st_d = H_IDLE;
						sda_oe_d = 1'b0;
						rv_d = 1'b1;
						rdat_d = sh_q;
						nack_d = !rd_q && sda_s;
						case (idx_q)
							IDX_SLA: idx_d = sh_q[0] ? IDX_DATA : IDX_REGA;
							IDX_REGA: begin
								idx_d = IDX_DATA;
								ptr_d = sh_q[7:4];
							end
							default: ptr_d = ptr_q + 4'h1;
						endcase
					end else begin
						sh_d = {sh_q[6:0], sda_s};
						bit_d = bit_q + 4'h1;
						// ack slot: drive only when acking a read
						sda_oe_d = (bit_q == 4'h7) ? (rd_q && ack_q)
							: (!rd_q && !sh_q[6]);
					end
				end
			end
			default: st_d = H_IDLE;
		endcase
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			st_q <= H_IDLE;
			ph_q <= '0;
			bit_q <= '0;
			tm_q <= '0;
			xt_q <= '0;
			sh_q <= '0;
			rdat_q <= '0;
			ptr_q <= PTR_RESET;
			idx_q <= IDX_SLA;
		end else if (CE) begin
			st_q <= st_d;
			ph_q <= ph_d;
			bit_q <= bit_d;
			tm_q <= tm_d;
			xt_q <= xt_d;
			sh_q <= sh_d;
			rdat_q <= rdat_d;
			ptr_q <= ptr_d;
			idx_q <= idx_d;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
			rd_q <= 1'b0;
			ack_q <= 1'b0;
			busy_q <= 1'b0;
			rv_q <= 1'b0;
			nack_q <= 1'b0;
			err_q <= 1'b0;
		end else if (CE) begin
			scl_oe_q <= scl_oe_d;
			sda_oe_q <= sda_oe_d;
			rd_q <= rd_d;
			ack_q <= ack_d;
			busy_q <= busy_d;
			rv_q <= rv_d;
			nack_q <= nack_d;
			err_q <= err_d;
		end
	end

	// open drain: only ever drive low
	assign BUS.host_scl_o = 1'b0;
	assign BUS.host_scl_oe = scl_oe_q;
	assign BUS.host_sda_o = 1'b0;
	assign BUS.host_sda_oe = sda_oe_q;
	assign RSP_VALID = rv_q;
	assign RSP_RDATA = rdat_q;
	assign RSP_NACK = nack_q;
	assign RSP_ERR = err_q;
	assign BUSY = busy_q;
endmodule

// ### dv/rtci_asserts.sv
// assertions on the two-wire bus between host and rtc ends
`timescale 1ns/100ps
module rtci_asserts #(
	parameter int TOUT_CYCLES = 2000,
	parameter int GAP_CYCLES = 20
) (
	// clock and reset
	input wire logic CLK,
	input wire logic RST,
	// bus drivers and resolved lines
	input wire logic host_scl_o,
	input wire logic host_scl_oe,
	input wire logic host_sda_o,
	input wire logic host_sda_oe,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe,
	input wire logic scl,
	input wire logic sda
);
	logic scl_q, sda_q, xact_q;
	logic [3:0] cnt_q, flags_q;
	logic [7:0] sh_q;
	int tcnt_q, gcnt_q;
	wire rise = scl && !scl_q;
	wire start = scl && scl_q && sda_q && !sda;
	wire stop = scl && scl_q && !sda_q && sda;
	wire bit9 = rise && cnt_q == 4'h8;
	wire hit = sh_q[7:1] == 7'h32;
	wire first = flags_q[3];
	wire mute = flags_q[1];
	wire nak = flags_q[0];
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	// bit position, restarted by any start, and shifted byte
	always_ff @(posedge CLK) begin
		scl_q <= scl;
		sda_q <= sda;
		if (start) cnt_q <= 4'h0;
		else if (rise) cnt_q <= (cnt_q == 4'h8) ? 4'h0 : cnt_q + 4'h1;
		if (rise && cnt_q != 4'h8) sh_q <= {sh_q[6:0], sda};
	end
	// flags: first byte, read mode, address miss, master nack
	always_ff @(posedge CLK) begin
		if (RST || stop) flags_q <= 4'h0;
		else if (start) flags_q <= 4'h8;
		else if (bit9 && first) flags_q <= {1'b0, sh_q[0] && hit, !hit, 1'b0};
		// read mode stays for every byte, so a late nack is still seen
		else if (bit9) flags_q <= {1'b0, flags_q[2], mute,
			nak || (flags_q[2] && sda)};
	end
	// transaction age is kept across repeated starts
	always_ff @(posedge CLK) begin
		if (RST || stop) xact_q <= 1'b0;
		else if (start) xact_q <= 1'b1;
		if (RST || (start && !xact_q)) tcnt_q <= 0;
		else if (xact_q) tcnt_q <= tcnt_q + 1;
		if (RST) gcnt_q <= GAP_CYCLES;
		else if (stop) gcnt_q <= 0;
		else if (gcnt_q < GAP_CYCLES) gcnt_q <= gcnt_q + 1;
	end
	property p_od;
		!host_scl_o && !host_sda_o && !dev_sda_o;
	endproperty
	a_od: assert property (p_od) else $error("line driven high");
	property p_dev_chg;
		$changed(dev_sda_oe) |-> !scl && !$past(scl);
	endproperty
	a_dev_chg: assert property (p_dev_chg) else $error("rtc edge clk high");
	property p_host_cond;
		$changed(host_sda_oe) && !host_scl_oe |-> !$past(host_scl_oe, 4);
	endproperty
	a_host_cond: assert property (p_host_cond) else $error("bad condition");
	property p_ack;
		bit9 && first |-> sda == !hit;
	endproperty
	a_ack: assert property (p_ack) else $error("address ack wrong");
	property p_hold;
		$rose(dev_sda_oe) |-> dev_sda_oe [*8];
	endproperty
	a_hold: assert property (p_hold) else $error("rtc drive too short");
	property p_nak;
		nak |-> !dev_sda_oe;
	endproperty
	a_nak: assert property (p_nak) else $error("drive after nack");
	property p_mute;
		mute |-> !dev_sda_oe;
	endproperty
	a_mute: assert property (p_mute) else $error("drive after miss");
	property p_tout;
		tcnt_q > TOUT_CYCLES + 8 |-> !dev_sda_oe;
	endproperty
	a_tout: assert property (p_tout) else $error("drive after timeout");
	property p_gap;
		start |-> gcnt_q >= GAP_CYCLES;
	endproperty
	a_gap: assert property (p_gap) else $error("start too soon");
	c_rstart: cover property (start && xact_q);
	c_nak: cover property ($rose(nak));
	c_tout: cover property (tcnt_q == TOUT_CYCLES);
endmodule

// ### dv/rtci_tb.sv
// self-checking bench joining host and rtc ends over the bus
`timescale 1ns/100ps
module rtci_tb import rtci_pkg::*;;
	localparam int H = 8;
	localparam int TO = 2000;
	localparam int GAP = 20;
	localparam int LIM = 4000;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cmd_valid, cmd_ready, cmd_ack, rsp_valid, rsp_nack, rsp_err;
	logic reg_we, carry, tout;
	logic exp_err, reg_re, hbusy;
	int re_n;
	logic [1:0] cmd_op;
	logic [7:0] cmd_wdata, rsp_rdata, reg_wdata, mon;
	logic [3:0] reg_addr;
	logic [7:0] mem [16];
	int err_total = 0;
	int compares = 0;
	int mon_n, tout_n;
	always #4 clk = !clk;
	rtci_if bus ();
	rtci_dev #(.TOUT_CYCLES(TO)) i_rtci_dev (.CLK(clk), .RST(rst),
		.CE(1'b1), .BUS(bus.dev), .REG_ADDR(reg_addr),
		.REG_WDATA(reg_wdata), .REG_WE(reg_we), .REG_RDATA(mem[reg_addr]),
		.REG_RE(reg_re), .CARRY_HOLD(carry), .TIMEOUT(tout));
	// host limit above the rtc one so the timeout can be reached
	rtci_host #(.HALF_CYCLES(H), .GAP_CYCLES(GAP), .XACT_CYCLES(2 * TO))
		i_rtci_host (.CLK(clk), .RST(rst), .CE(1'b1), .BUS(bus.host),
		.CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_OP(cmd_op),
		.CMD_WDATA(cmd_wdata), .CMD_ACK(cmd_ack), .RSP_VALID(rsp_valid),
		.RSP_RDATA(rsp_rdata), .RSP_NACK(rsp_nack), .RSP_ERR(rsp_err),
		.BUSY(hbusy));
	rtci_asserts #(.TOUT_CYCLES(TO), .GAP_CYCLES(GAP)) i_rtci_asserts (
		.CLK(clk), .RST(rst), .host_scl_o(bus.host_scl_o),
		.host_scl_oe(bus.host_scl_oe), .host_sda_o(bus.host_sda_o),
		.host_sda_oe(bus.host_sda_oe), .dev_sda_o(bus.dev_sda_o),
		.dev_sda_oe(bus.dev_sda_oe), .scl(bus.scl), .sda(bus.sda));
	// register core stand-in, read side combinational
	always @(posedge clk) begin
		if (reg_we) mem[reg_addr] <= reg_wdata;
		if (tout) tout_n++;
		if (reg_re) re_n++;
	end
	// first eight wire bits after a restart of the count
	always @(posedge bus.scl) begin
		if (mon_n < 8) begin
			mon <= {mon[6:0], bus.sda};
			mon_n++;
		end
	end
	task print_verdict;
		$display("errors %0d compares %0d", err_total, compares);
		if (err_total == 0 && compares > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one host command; entered and left at a falling edge
	task cmd(input logic [1:0] op, input logic [7:0] d, input logic a);
		int n;
		n = 0;
		while (cmd_ready !== 1'b1 && n < LIM) begin
			@(negedge clk);
			n++;
		end
		@(posedge clk);
		cmd_op <= op;
		cmd_wdata <= d;
		cmd_ack <= a;
		cmd_valid <= 1'b1;
		@(posedge clk);
		cmd_valid <= 1'b0;
		@(negedge clk);
		while (rsp_valid !== 1'b1 && n < LIM) begin
			@(negedge clk);
			n++;
		end
		if (n >= LIM) begin
			err_total++;
			print_verdict;
		end else begin
			chk(rsp_err, exp_err);
		end
	endtask
	task s_write;
		cmd(OP_START, 8'h00, 1'b0);
		chk(carry, 1'b1);
		chk(hbusy, 1'b1);
		mon_n = 0;
		cmd(OP_WRITE, SLA_WR, 1'b0);
		chk(mon, SLA_WR);
		chk(rsp_nack, 1'b0);
		cmd(OP_WRITE, 8'he0, 1'b0);
		chk(rsp_nack, 1'b0);
		cmd(OP_WRITE, 8'h3c, 1'b0);
		cmd(OP_WRITE, 8'h25, 1'b0);
		cmd(OP_WRITE, 8'h5a, 1'b0);
		cmd(OP_STOP, 8'h00, 1'b0);
		chk(carry, 1'b0);
		chk(hbusy, 1'b0);
		chk(mem[14], 8'h3c);
		chk(mem[15], 8'h25);
		chk(mem[0], 8'h5a);
	endtask
	task s_read_f;
		re_n = 0;
		cmd(OP_START, 8'h00, 1'b0);
		cmd(OP_WRITE, SLA_RD, 1'b0);
		chk(rsp_nack, 1'b0);
		cmd(OP_READ, 8'h00, 1'b1);
		chk(rsp_rdata, 8'h25);
		cmd(OP_READ, 8'h00, 1'b0);
		chk(rsp_rdata, 8'h5a);
		cmd(OP_STOP, 8'h00, 1'b0);
		chk(8'({bus.scl, bus.sda}), 8'h03);
		// two loads only: none after the master nack
		chk(8'(re_n), 8'h02);
	endtask
	// refused commands leave the bus and the registers alone
	task s_refuse;
		exp_err = 1'b1;
		cmd(OP_STOP, 8'h00, 1'b0);
		exp_err = 1'b0;
		cmd(OP_START, 8'h00, 1'b0);
		cmd(OP_WRITE, SLA_WR, 1'b0);
		cmd(OP_WRITE, 8'hd0, 1'b0);
		exp_err = 1'b1;
		cmd(OP_WRITE, 8'h77, 1'b0);
		exp_err = 1'b0;
		chk(mem[13], 8'h0d);
		cmd(OP_STOP, 8'h00, 1'b0);
	endtask
	task s_rstart;
		cmd(OP_START, 8'h00, 1'b0);
		cmd(OP_WRITE, SLA_WR, 1'b0);
		cmd(OP_WRITE, 8'he0, 1'b0);
		cmd(OP_START, 8'h00, 1'b0);
		cmd(OP_WRITE, SLA_RD, 1'b0);
		cmd(OP_READ, 8'h00, 1'b0);
		chk(rsp_rdata, 8'h3c);
		cmd(OP_STOP, 8'h00, 1'b0);
	endtask
	task s_badaddr;
		logic [7:0] bad [2];
		bad = '{8'h66, 8'he4};
		for (int i = 0; i < 2; i++) begin
			cmd(OP_START, 8'h00, 1'b0);
			cmd(OP_WRITE, bad[i], 1'b0);
			chk(rsp_nack, 1'b1);
			cmd(OP_STOP, 8'h00, 1'b0);
		end
	endtask
	// stop right after the pointer byte, then a fresh read from the top
	task s_abort;
		cmd(OP_START, 8'h00, 1'b0);
		cmd(OP_WRITE, SLA_WR, 1'b0);
		cmd(OP_WRITE, 8'h10, 1'b0);
		cmd(OP_STOP, 8'h00, 1'b0);
		chk(mem[1], 8'h01);
		cmd(OP_START, 8'h00, 1'b0);
		cmd(OP_WRITE, SLA_RD, 1'b0);
		cmd(OP_READ, 8'h00, 1'b0);
		chk(rsp_rdata, 8'h25);
		cmd(OP_STOP, 8'h00, 1'b0);
	endtask
	task s_tout;
		cmd(OP_START, 8'h00, 1'b0);
		cmd(OP_WRITE, SLA_RD, 1'b0);
		tout_n = 0;
		repeat (TO + 200) @(negedge clk);
		chk(8'(tout_n), 8'h01);
		chk(carry, 1'b0);
		cmd(OP_READ, 8'h00, 1'b0);
		chk(rsp_rdata, 8'hff);
		cmd(OP_STOP, 8'h00, 1'b0);
	endtask
	initial begin
		cmd_valid = 1'b0;
		cmd_op = 2'h0;
		cmd_wdata = 8'h00;
		cmd_ack = 1'b0;
		mon_n = 8;
		tout_n = 0;
		re_n = 0;
		exp_err = 1'b0;
		for (int i = 0; i < 16; i++) mem[i] = 8'(i);
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		s_write;
		s_read_f;
		s_rstart;
		s_badaddr;
		s_abort;
		s_refuse;
		s_tout;
		print_verdict;
	end
endmodule
